// ### hw/hub_rst_pkg.sv
// Shared constants and types for the hub reset and link power block
package hub_rst_pkg;

    // Core clock period in ns (25 MHz)
    localparam int CLK_PERIOD_NS = 40;

    // Power-on hold interval (no figure given; plain default)
    localparam int POR_HOLD_US = 100;
    localparam int POR_HOLD_CYC = (POR_HOLD_US * 1000) / CLK_PERIOD_NS;

    // Clock restart settle after the pin reset lifts
    localparam int OSC_SETTLE_US = 50;
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_US * 1000) / CLK_PERIOD_NS;

    // Link power latencies
    localparam int SUSP_ENTRY_US = 3000;
    localparam int SUSP_ENTRY_CYC = (SUSP_ENTRY_US * 1000) / CLK_PERIOD_NS;
    localparam int SUSP_EXIT_US = 2000;
    localparam int SUSP_EXIT_CYC = (SUSP_EXIT_US * 1000) / CLK_PERIOD_NS;
    // Sleep loads two short: the load edge and the state step cost a cycle each
    localparam int SLEEP_ENTRY_NS = 10000;
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS - 2;
    localparam int SLEEP_EXIT_NS = 50000;
    localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_NS / CLK_PERIOD_NS - 2;

    // Counter width covers the largest count
    localparam int CNT_W = 20;

    // Address and configuration defaults
    localparam logic [6:0] ADDR_DEFAULT = 7'h00;
    localparam logic [7:0] CONFIG_UNCONFIGURED = 8'h00;

    // Link power state, Gray order along the sleep path on -> entering -> low -> exiting
    typedef enum logic [2:0] {
        LINK_ON = 3'h0,
        LINK_ENTER_SLEEP = 3'h1,
        LINK_SLEEP = 3'h3,
        LINK_EXIT_SLEEP = 3'h2,
        LINK_ENTER_SUSP = 3'h6,
        LINK_SUSP = 3'h7,
        LINK_EXIT_SUSP = 3'h5
    } link_state_t;

    // Link power requests from the protocol layer
    typedef struct packed {
        logic sleep_req;
        logic suspend_req;
        logic resume_start;
        logic wake_req;
    } link_req_t;

    // Link power status bundle
    typedef struct packed {
        logic link_on_state;
        logic link_sleep_state;
        logic link_suspend_state;
        logic busy;
    } link_stat_t;

    // Device enumeration state set by the host
    typedef struct packed {
        logic set_addr;
        logic [6:0] addr;
        logic set_config;
        logic [7:0] config_value;
    } enum_req_t;

endpackage

// ### hw/rst_sync3.sv
// Three-stage synchroniser for the external reset pin
`timescale 1ns/1ns
`default_nettype none
module rst_sync3 (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Raw pin level
    input wire logic pin_i,
    // Filtered level, changes once stages two and three agree
    output logic level_o
);
    logic [2:0] sync_reg;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_i};
        end
    end

    // Accept a change only when the later stages match
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_o <= 1'b0;
        end else if (sync_reg[1] == sync_reg[2]) begin
            level_o <= sync_reg[2];
        end
    end
endmodule
`default_nettype wire

// ### hw/delay_timer.sv
// Down-counting one-shot timer
`timescale 1ns/1ns
`default_nettype none
module delay_timer (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Load and count
    input wire logic load_i,
    input wire logic [hub_rst_pkg::CNT_W-1:0] count_i,
    // Expiry level
    output logic done_o
);
    logic [hub_rst_pkg::CNT_W-1:0] cnt_reg;

    // Load wins over counting so a fresh request restarts the wait
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
        end else if (load_i) begin
            cnt_reg <= count_i;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Done when the count has run out and no load is pending
    assign done_o = (cnt_reg == '0) && !load_i;
endmodule
`default_nettype wire

// ### hw/hub_reset_and_link_power_states.sv
// Chip reset handling and link power state control for the hub core
//
// How it works
// R1: Three reset sources: power-on, external active-low pin, upstream bus reset.
// R2: On power-up a timer holds internal reset for a fixed interval.
// R3: While the pin reset is low the chip sits in low-current standby.
// R4: Pin reset disables the PHY and floats all differential pairs.
// R5: Pin reset aborts every transaction at once, nothing kept.
// R6: Pin reset returns every internal register to its default; the power-on hold timer and its load flop keep their values, the settle timer reloads its count.
// R7: Pin reset stops the oscillator and PLL while held.
// R8: Upstream bus reset sets the device address to zero.
// R9: Upstream bus reset returns the configuration to unconfigured.
// R10: Bus reset while suspended moves the link back to on.
// R11: Upstream bus reset is never passed to downstream ports.
// R12: Host re-enumerates the device after its bus reset.
// R13: Three link power states: on, sleep and suspend.
// R14: Suspend entry about 3 ms; back on about 2 ms after resume.
// R15: Sleep entry under 10 us; sleep exit under 50 us.
// R16: Pin reset asserts at once, releases synchronously after clocks restart.
`timescale 1ns/1ns
`default_nettype none
module hub_reset_and_link_power_states #(
    parameter int POR_CYC = hub_rst_pkg::POR_HOLD_CYC,
    parameter int SETTLE_CYC = hub_rst_pkg::OSC_SETTLE_CYC,
    parameter int SUSP_IN_CYC = hub_rst_pkg::SUSP_ENTRY_CYC,
    parameter int SUSP_OUT_CYC = hub_rst_pkg::SUSP_EXIT_CYC
) (
    // Clock and power-on reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // External chip reset pin, active low
    input wire logic chip_reset_n_i,
    // Upstream bus reset detected, same clock
    input wire logic bus_reset_i,
    // Link power and enumeration requests
    input wire hub_rst_pkg::link_req_t link_req_i,
    input wire hub_rst_pkg::enum_req_t enum_req_i,
    // Core reset and clock control
    output logic core_reset_n_o,
    output logic standby_o,
    output logic osc_enable_o,
    output logic pll_enable_o,
    // PHY control
    output logic phy_enable_o,
    output logic phy_pair_oe_o,
    output logic txn_abort_o,
    output logic downstream_reset_o,
    // Enumeration state
    output logic [6:0] dev_addr_o,
    output logic [7:0] dev_config_o,
    // Link power status
    output hub_rst_pkg::link_stat_t link_stat_o
);
    logic pin_level;
    logic por_done;
    logic settle_done;
    logic link_done;
    logic pin_low_reg;
    logic por_load_reg;
    logic settle_load;
    logic link_load;
    logic [hub_rst_pkg::CNT_W-1:0] link_count;
    logic core_rst_n_reg;
    logic core_rst_n_next;
    hub_rst_pkg::link_state_t link_reg;
    hub_rst_pkg::link_state_t link_next;
    logic [hub_rst_pkg::CNT_W-1:0] exit_cyc_reg;

    // Pin passes four flops before use
    rst_sync3 u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(chip_reset_n_i),
        .level_o(pin_level)
    );

    // Asserting edge acts at once; the synchronised level only governs release
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_low_reg <= 1'b1;
        end else begin
            pin_low_reg <= !pin_level || !chip_reset_n_i; // R16
        end
    end

    // One load pulse after power-on starts the hold timer
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            por_load_reg <= 1'b1;
        end else begin
            por_load_reg <= 1'b0;
        end
    end

    delay_timer u_por_timer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(por_load_reg),
        .count_i(hub_rst_pkg::CNT_W'(POR_CYC)),
        .done_o(por_done)
    );

    // Settle timer restarts for as long as the pin holds reset
    assign settle_load = pin_low_reg;

    delay_timer u_settle_timer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(settle_load),
        .count_i(hub_rst_pkg::CNT_W'(SETTLE_CYC)),
        .done_o(settle_done)
    );

    // Internal reset held until power-on hold ends and clocks have settled
    assign core_rst_n_next = por_done && settle_done && !pin_low_reg && chip_reset_n_i; // R1 R2 R16

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_rst_n_reg <= 1'b0;
        end else begin
            core_rst_n_reg <= core_rst_n_next;
        end
    end

    // Standby and clock gating follow the pin directly; settle covers restart
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            standby_o <= 1'b1;
            osc_enable_o <= 1'b0;
            pll_enable_o <= 1'b0;
        end else begin
            standby_o <= pin_low_reg; // R3
            osc_enable_o <= !pin_low_reg; // R7
            pll_enable_o <= !pin_low_reg; // R7
        end
    end

    // PHY floated and traffic aborted whenever core reset is in force
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phy_enable_o <= 1'b0;
            phy_pair_oe_o <= 1'b0;
            txn_abort_o <= 1'b1;
        end else begin
            phy_enable_o <= core_rst_n_next; // R4
            phy_pair_oe_o <= core_rst_n_next; // R4
            txn_abort_o <= !core_rst_n_next; // R5
        end
    end

    // Bus reset stays local to the upstream side
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            downstream_reset_o <= 1'b0;
        end else begin
            downstream_reset_o <= 1'b0; // R11
        end
    end

    // Address and configuration; bus reset beats a same-cycle host write
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dev_addr_o <= hub_rst_pkg::ADDR_DEFAULT;
            dev_config_o <= hub_rst_pkg::CONFIG_UNCONFIGURED;
        end else if (!core_rst_n_reg) begin
            dev_addr_o <= hub_rst_pkg::ADDR_DEFAULT; // R6
            dev_config_o <= hub_rst_pkg::CONFIG_UNCONFIGURED; // R6
        end else if (bus_reset_i) begin
            dev_addr_o <= hub_rst_pkg::ADDR_DEFAULT; // R8
            dev_config_o <= hub_rst_pkg::CONFIG_UNCONFIGURED; // R9
        end else begin
            if (enum_req_i.set_addr) begin
                dev_addr_o <= enum_req_i.addr; // R12
            end
            if (enum_req_i.set_config) begin
                dev_config_o <= enum_req_i.config_value;
            end
        end
    end

    // Link state step; a timed phase loads on entry and finishes on expiry
    always_comb begin
        link_next = link_reg;
        link_load = 1'b0;
        link_count = '0;
        case (link_reg)
            hub_rst_pkg::LINK_ON: begin
                if (link_req_i.suspend_req) begin
                    link_next = hub_rst_pkg::LINK_ENTER_SUSP;
                    link_load = 1'b1;
                    link_count = hub_rst_pkg::CNT_W'(SUSP_IN_CYC); // R14
                end else if (link_req_i.sleep_req) begin
                    link_next = hub_rst_pkg::LINK_ENTER_SLEEP;
                    link_load = 1'b1;
                    link_count = hub_rst_pkg::CNT_W'(hub_rst_pkg::SLEEP_ENTRY_CYC); // R15
                end
            end
            hub_rst_pkg::LINK_ENTER_SLEEP: begin
                if (link_done) begin
                    link_next = hub_rst_pkg::LINK_SLEEP;
                end
            end
            hub_rst_pkg::LINK_SLEEP: begin
                if (link_req_i.wake_req) begin
                    link_next = hub_rst_pkg::LINK_EXIT_SLEEP;
                    link_load = 1'b1;
                    link_count = hub_rst_pkg::CNT_W'(hub_rst_pkg::SLEEP_EXIT_CYC); // R15
                end
            end
            hub_rst_pkg::LINK_EXIT_SLEEP: begin
                if (link_done) begin
                    link_next = hub_rst_pkg::LINK_ON;
                end
            end
            hub_rst_pkg::LINK_ENTER_SUSP: begin
                if (link_done) begin
                    link_next = hub_rst_pkg::LINK_SUSP;
                end
            end
            hub_rst_pkg::LINK_SUSP: begin
                if (link_req_i.resume_start) begin
                    link_next = hub_rst_pkg::LINK_EXIT_SUSP;
                    link_load = 1'b1;
                    link_count = hub_rst_pkg::CNT_W'(SUSP_OUT_CYC); // R14
                end
            end
            hub_rst_pkg::LINK_EXIT_SUSP: begin
                if (link_done) begin
                    link_next = hub_rst_pkg::LINK_ON;
                end
            end
            default: begin
                link_next = hub_rst_pkg::LINK_ON;
            end
        endcase
        // Bus reset forces the link straight back on
        if (bus_reset_i) begin
            link_next = hub_rst_pkg::LINK_ON; // R10
            link_load = 1'b0;
        end
        // Core reset parks the link on and empties the timer, so no stale wait survives
        if (!core_rst_n_next) begin
            link_next = hub_rst_pkg::LINK_ON; // R6
            link_load = 1'b1;
            link_count = '0;
        end
    end

    delay_timer u_link_timer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(link_load),
        .count_i(link_count),
        .done_o(link_done)
    );

    // Link state register; core reset restores the on state
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link_reg <= hub_rst_pkg::LINK_ON;
        end else if (!core_rst_n_reg) begin
            link_reg <= hub_rst_pkg::LINK_ON; // R6
        end else begin
            link_reg <= link_next; // R13
        end
    end

    // Registered status view of the link
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link_stat_o <= '0;
            core_reset_n_o <= 1'b0;
        end else begin
            link_stat_o.link_on_state <= (link_next == hub_rst_pkg::LINK_ON);
            link_stat_o.link_sleep_state <= (link_next == hub_rst_pkg::LINK_SLEEP);
            link_stat_o.link_suspend_state <= (link_next == hub_rst_pkg::LINK_SUSP);
            link_stat_o.busy <= link_load || !link_done;
            core_reset_n_o <= core_rst_n_next; // R1
        end
    end

    // Cycles spent leaving sleep; a counter stands in for a long delay range
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exit_cyc_reg <= '0;
        end else if (link_reg == hub_rst_pkg::LINK_EXIT_SLEEP) begin
            exit_cyc_reg <= exit_cyc_reg + 1'b1; // R15
        end else begin
            exit_cyc_reg <= '0;
        end
    end

    // Assertions
    pin_float_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R4
        $fell(chip_reset_n_i) |=> !phy_pair_oe_o && !phy_enable_o)
        else $error("pairs not floated after pin reset");

    pin_abort_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R5
        $fell(chip_reset_n_i) |=> txn_abort_o && !core_reset_n_o)
        else $error("transactions not aborted on pin reset");

    clk_halt_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R7
        !chip_reset_n_i ##1 !chip_reset_n_i |=> !osc_enable_o && !pll_enable_o && standby_o)
        else $error("clocks running under pin reset");

    bus_addr_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R8
        bus_reset_i |=> dev_addr_o == hub_rst_pkg::ADDR_DEFAULT)
        else $error("address not cleared by bus reset");

    bus_config_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R9
        bus_reset_i |=> dev_config_o == hub_rst_pkg::CONFIG_UNCONFIGURED)
        else $error("configuration not cleared by bus reset");

    susp_wake_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R10
        bus_reset_i && core_rst_n_reg |=> link_stat_o.link_on_state)
        else $error("bus reset left link suspended");

    no_forward_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R11
        bus_reset_i |=> !downstream_reset_o)
        else $error("bus reset forwarded downstream");

    sleep_entry_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R15
        link_reg == hub_rst_pkg::LINK_ON && link_next == hub_rst_pkg::LINK_ENTER_SLEEP
        |-> ##[1:250] link_reg != hub_rst_pkg::LINK_ENTER_SLEEP)
        else $error("sleep entry too slow");

    sleep_exit_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R15
        exit_cyc_reg < hub_rst_pkg::CNT_W'(hub_rst_pkg::SLEEP_EXIT_NS / hub_rst_pkg::CLK_PERIOD_NS))
        else $error("sleep exit too slow");

    por_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R2
        !por_done |=> !core_reset_n_o)
        else $error("core released before power-on hold");
endmodule
`default_nettype wire

// ### tb/hub_host_model.sv
// Upstream host and board reset source that drive the hub core
`timescale 1ns/1ns
`default_nettype none
module hub_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Board reset pin and upstream bus reset
    output logic chip_reset_n_o,
    output logic bus_reset_o,
    // Protocol requests
    output hub_rst_pkg::link_req_t link_req_o,
    output hub_rst_pkg::enum_req_t enum_req_o
);
    localparam int DLY = 2;

    // Idle levels at time zero
    initial begin
        chip_reset_n_o = 1'b1;
        bus_reset_o = 1'b0;
        link_req_o = '0;
        enum_req_o = '0;
    end

    // Board pin, changes at once like a real push button
    task automatic set_pin(input logic level);
        chip_reset_n_o = level;
    endtask

    // One-cycle link request, caller stands just after an edge
    task automatic link_pulse(input hub_rst_pkg::link_req_t req);
        link_req_o = req;
        @(posedge sys_clk_i);
        #DLY;
        link_req_o = '0;
    endtask

    // One host write; data lines turn over afterwards so a late capture shows
    task automatic write_enum(input logic sa, input logic [6:0] addr, input logic sc, input logic [7:0] cfg);
        enum_req_o = '{sa, addr, sc, cfg};
        @(posedge sys_clk_i);
        #DLY;
        enum_req_o = '{1'b0, ~addr, 1'b0, ~cfg};
    endtask

    // Bus reset with a clashing host write in the same cycle
    task automatic bus_reset(input logic [6:0] addr);
        bus_reset_o = 1'b1;
        enum_req_o = '{1'b1, addr, 1'b1, {1'b1, addr}};
        @(posedge sys_clk_i);
        #DLY;
        bus_reset_o = 1'b0;
        enum_req_o = '{1'b0, ~addr, 1'b0, 8'hFF};
    endtask

    // Re-enumeration after the bus reset, address then configuration back to back
    task automatic enumerate(input logic [6:0] addr, input logic [7:0] cfg);
        enum_req_o = '{1'b1, addr, 1'b0, ~cfg};
        @(posedge sys_clk_i);
        #DLY;
        enum_req_o = '{1'b0, ~addr, 1'b1, cfg};
        @(posedge sys_clk_i);
        #DLY;
        enum_req_o = '{1'b0, addr, 1'b0, ~cfg};
    endtask
endmodule
`default_nettype wire

// ### tb/test_hub_reset_and_link_power_states.sv
// Self-checking bench for the hub reset and link power block
`timescale 1ns/1ns
`default_nettype none
module test_hub_reset_and_link_power_states;
    localparam int POR = 20;
    localparam int SETTLE = 10;
    localparam int SIN = 30;
    localparam int SOUT = 20;
    localparam int SLP_IN = hub_rst_pkg::SLEEP_ENTRY_CYC;
    localparam int SLP_OUT = hub_rst_pkg::SLEEP_EXIT_CYC;

    logic sys_clk_i;
    logic reset_n_i;
    wire logic chip_reset_n;
    wire logic bus_reset;
    wire hub_rst_pkg::link_req_t link_req;
    wire hub_rst_pkg::enum_req_t enum_req;
    logic core_reset_n, standby, osc_en, pll_en, phy_en, pair_oe, abort, ds_reset;
    logic [6:0] dev_addr;
    logic [7:0] dev_config;
    hub_rst_pkg::link_stat_t link_stat;
    logic [3:0] ls;
    int num_errors = 0;
    int tests_run = 0;
    int seed = 88;
    int n;
    logic [6:0] a;
    logic [7:0] c;

    // Flat view: on, sleep, suspend, busy
    assign ls = link_stat;

    hub_host_model host (
        .sys_clk_i(sys_clk_i), .chip_reset_n_o(chip_reset_n), .bus_reset_o(bus_reset),
        .link_req_o(link_req), .enum_req_o(enum_req)
    );

    // Short counts keep the run small
    hub_reset_and_link_power_states #(
        .POR_CYC(POR), .SETTLE_CYC(SETTLE), .SUSP_IN_CYC(SIN), .SUSP_OUT_CYC(SOUT)
    ) i_dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .chip_reset_n_i(chip_reset_n),
        .bus_reset_i(bus_reset), .link_req_i(link_req), .enum_req_i(enum_req),
        .core_reset_n_o(core_reset_n), .standby_o(standby), .osc_enable_o(osc_en),
        .pll_enable_o(pll_en), .phy_enable_o(phy_en), .phy_pair_oe_o(pair_oe),
        .txn_abort_o(abort), .downstream_reset_o(ds_reset), .dev_addr_o(dev_addr),
        .dev_config_o(dev_config), .link_stat_o(link_stat)
    );

    // 25 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // Step to just after an edge, where drives change and outputs are settled
    task automatic tick(input int k = 1);
        repeat (k) @(posedge sys_clk_i);
        #2;
    endtask

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Request a transition, see busy at once, then time the arrival
    task automatic link_step(input string what, input logic [3:0] req, input logic [3:0] pat,
                             input int lo, input int hi);
        host.link_pulse(hub_rst_pkg::link_req_t'(req));
        check_val({what, "_busy"}, 8'h01, {7'h00, ls[0]});
        n = 1;
        while (ls !== pat && n < hi + 5) begin
            tick();
            n++;
        end
        check_range(what, lo, hi, n);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, well above the fewer than two thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        finish_test();
    end

    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        tick(5);
        check_val("core_in_por", 8'h00, {7'h00, core_reset_n});
        reset_n_i = 1'b1;
        n = 0;
        while (core_reset_n !== 1'b1 && n < POR + SETTLE + 20) begin
            tick();
            n++;
        end
        check_range("por_hold", POR, POR + SETTLE + 8, n);
        check_val("link_after_por", 8'h08, {4'h0, ls});
        check_val("clocks_phy_on", 8'h07, {5'h00, osc_en, pll_en, phy_en});
        $display("test power_on done");

        // Random host writes with random gaps
        repeat (8) begin
            a = 7'($random(seed));
            c = 8'($random(seed));
            host.write_enum(1'b1, a, 1'b1, c);
            check_val("dev_addr", {1'b0, a}, {1'b0, dev_addr});
            check_val("dev_config", c, dev_config);
            tick(1 + ($random(seed) & 3));
        end
        $display("test enum_writes done");

        // Bus reset beats a same-cycle write, nothing forwarded downstream
        host.bus_reset(a | 7'h01);
        check_val("addr_bus_reset", 8'h00, {1'b0, dev_addr});
        check_val("config_bus_reset", 8'h00, dev_config);
        check_val("downstream_reset", 8'h00, {7'h00, ds_reset});
        check_val("core_kept", 8'h01, {7'h00, core_reset_n});
        host.enumerate(a, c);
        check_val("addr_reenum", {1'b0, a}, {1'b0, dev_addr});
        check_val("config_reenum", c, dev_config);
        $display("test bus_reset done");

        // Wake in the on state is ignored
        host.link_pulse(hub_rst_pkg::link_req_t'(4'h1));
        tick();
        check_val("wake_refused", 8'h08, {4'h0, ls});
        link_step("sleep_entry", 4'h8, 4'h4, SLP_IN - 1, SLP_IN + 3);
        tick(1 + ($random(seed) & 3));
        link_step("sleep_exit", 4'h1, 4'h8, SLP_OUT - 1, SLP_OUT + 3);
        // Suspend takes priority over a same-cycle sleep request
        link_step("susp_entry", 4'hC, 4'h2, SIN - 1, SIN + 3);
        link_step("susp_exit", 4'h2, 4'h8, SOUT - 1, SOUT + 3);
        link_step("susp_again", 4'h4, 4'h2, SIN - 1, SIN + 3);
        host.bus_reset(7'h7F);
        check_val("bus_reset_wakes", 8'h08, {4'h0, ls});
        $display("test link_power done");

        // Pin reset in the middle of a sleep entry
        host.enumerate(a | 7'h01, c | 8'h01);
        host.link_pulse(hub_rst_pkg::link_req_t'(4'h8));
        tick(5);
        host.set_pin(1'b0);
        tick();
        check_val("core_pin", 8'h00, {7'h00, core_reset_n});
        check_val("phy_off", 8'h00, {6'h00, phy_en, pair_oe});
        check_val("abort", 8'h01, {7'h00, abort});
        tick();
        check_val("standby", 8'h01, {7'h00, standby});
        check_val("clocks_off", 8'h00, {6'h00, osc_en, pll_en});
        tick();
        check_val("addr_default", 8'h00, {1'b0, dev_addr});
        check_val("config_default", 8'h00, dev_config);
        tick(20);
        check_val("standby_held", 8'h01, {7'h00, standby});
        check_val("clocks_held", 8'h00, {6'h00, osc_en, pll_en});
        host.set_pin(1'b1);
        n = 0;
        while (core_reset_n !== 1'b1 && n < SETTLE + 20) begin
            tick();
            n++;
        end
        check_range("pin_release", SETTLE + 1, SETTLE + 8, n);
        check_val("clocks_back", 8'h07, {5'h00, osc_en, pll_en, phy_en});
        check_val("link_default", 8'h08, {4'h0, ls});
        check_val("abort_clear", 8'h00, {7'h00, abort});
        $display("test pin_reset done");
        finish_test();
    end
endmodule
`default_nettype wire
